//--- verilog/cpc_charger_protection.sv
// fault supervision, option control and word register port of the charger
`timescale 1ns/100ps
`include "cpc_consts.svh"
module cpc_charger_protection import cpc_pkg::*; #(
	parameter logic [6:0] BUS_ADDR = 7'h09, // bus address of the block
	parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
	parameter logic [15:0] PART_CODE = 16'h005A, // arbitrary value
	parameter logic [20:0] INPUT_OVERCURRENT_TRIP_BLANK_CYC =
		21'($ceil(`CPC_INPUT_OVERCURRENT_TRIP_BLANK_MS * 1.0e6 / `CPC_CLK_PERIOD_NS)),
	parameter logic [20:0] OVP_DISABLE_CYC =
		21'($ceil(`CPC_OVP_DISABLE_MS * 1.0e6 / `CPC_CLK_PERIOD_NS)),
	parameter logic [20:0] BATLOW_RESET_CYC =
		21'($ceil(`CPC_BATLOW_RESET_MS * 1.0e6 / `CPC_CLK_PERIOD_NS)),
	parameter logic [20:0] BATLOW_RESTART_CYC =
		21'($ceil(`CPC_BATLOW_RESTART_MS * 1.0e6 / `CPC_CLK_PERIOD_NS))
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic smb_clk_in,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe,
	input wire cpc_analog_in_t analog_in,
	output cpc_drive_t drive_out
);
	////////////////////////////////////////////////////////////////////////////
	// input synchronisers: three stages, a change counts when stages two and three agree
	localparam int SYNC_W = 2 + $bits(cpc_analog_in_t);
	logic [SYNC_W-1:0] sync_a; // first stage, read only by sync_b
	logic [SYNC_W-1:0] sync_b;
	logic [SYNC_W-1:0] sync_c;
	logic [SYNC_W-1:0] filt; // agreed levels
	wire [SYNC_W-1:0] raw_in = {smb_clk_in, smb_data_in, analog_in};
	wire [SYNC_W-1:0] next_filt = (sync_b & sync_c) | (filt & (sync_b | sync_c));
	// shift the stages and hold the agreed level
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
			filt <= '0;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
			filt <= next_filt;
		end
	end
	cpc_analog_in_t ain; // filtered comparator levels
	wire scl_f = filt[SYNC_W-1];
	wire sda_f = filt[SYNC_W-2];
	assign ain = filt[SYNC_W-3:0];

	////////////////////////////////////////////////////////////////////////////
	// word register port
	cpc_smb_state_t smb_st; // transfer phase
	logic scl_q; // previous clock level
	logic sda_q; // previous data level
	logic [3:0] bit_cnt; // bits of the current byte
	logic ack_ph; // in the ninth clock
	logic [7:0] rx_sh; // received byte
	logic [7:0] tx_sh; // byte being sent
	logic [7:0] cmd_code; // selected register
	logic [7:0] lo_byte; // low byte of a write
	logic [15:0] opt_reg; // charge_options
	logic [15:0] cur_reg; // charge_current_setting
	logic [15:0] volt_reg; // charge_voltage_setting
	logic [15:0] inlim_reg; // input_current_limit
	wire scl_rise = scl_f & ~scl_q;
	wire scl_fall = ~scl_f & scl_q;
	wire start_det = scl_f & scl_q & sda_q & ~sda_f;
	wire stop_det = scl_f & scl_q & ~sda_q & sda_f;
	wire tx_state = (smb_st == CPC_SM_RLO) || (smb_st == CPC_SM_RHI);
	wire byte_end = scl_fall & ~ack_ph & (bit_cnt == 4'h8) & ~start_det & ~stop_det;
	wire addr_hit = (rx_sh[7:1] == BUS_ADDR);
	wire wr_strobe = byte_end & (smb_st == CPC_SM_WHI);
	wire [15:0] wr_word = {rx_sh, lo_byte};
	// options read with the live adapter indication in its read-only bit
	wire [15:0] opt_rd = (opt_reg & ~`CPC_MASK_OPT_RO) |
		(ain.adapter_detect_low ? 16'h0000 : `CPC_MASK_OPT_RO);
	// read selection by command code, unmapped codes read zero
	wire [15:0] rd_word = (cmd_code == `CPC_CMD_OPTIONS) ? opt_rd :
		(cmd_code == `CPC_CMD_CHG_CURRENT) ? cur_reg :
		(cmd_code == `CPC_CMD_CHG_VOLTAGE) ? volt_reg :
		(cmd_code == `CPC_CMD_INPUT_LIMIT) ? inlim_reg :
		(cmd_code == `CPC_CMD_MAKER) ? MAKER_CODE :
		(cmd_code == `CPC_CMD_PART) ? PART_CODE : 16'h0000;
	assign smb_data_out = 1'b0; // open drain: only pulls low

	// bit engine: start, stop, shifting, acknowledge and phase steps
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			smb_st <= CPC_SM_IDLE;
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			bit_cnt <= 4'h0;
			ack_ph <= 1'b0;
			rx_sh <= 8'h00;
			tx_sh <= 8'h00;
			cmd_code <= 8'h00;
			lo_byte <= 8'h00;
			smb_data_oe <= 1'b0;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
			if (start_det) begin
				// start or repeated start: expect the address byte
				smb_st <= CPC_SM_ADDR;
				bit_cnt <= 4'h0;
				ack_ph <= 1'b0;
				smb_data_oe <= 1'b0;
			end else if (stop_det) begin
				smb_st <= CPC_SM_IDLE;
				ack_ph <= 1'b0;
				smb_data_oe <= 1'b0;
			end else if (scl_rise) begin
				if (ack_ph) begin
					// master refuses more read data
					if (tx_state && sda_f) begin
						smb_st <= CPC_SM_DONE;
					end
				end else if (bit_cnt != 4'h8) begin
					rx_sh <= {rx_sh[6:0], sda_f};
					bit_cnt <= bit_cnt + 4'h1;
				end
			end else if (scl_fall && smb_st != CPC_SM_IDLE) begin
				if (ack_ph) begin
					// leave the ninth clock, put out the first read bit
					ack_ph <= 1'b0;
					bit_cnt <= 4'h0;
					smb_data_oe <= tx_state & ~tx_sh[7];
					tx_sh <= {tx_sh[6:0], 1'b0};
				end else if (bit_cnt == 4'h8) begin
					ack_ph <= 1'b1;
					unique case (smb_st)
						CPC_SM_ADDR: begin
							smb_data_oe <= addr_hit;
							smb_st <= !addr_hit ? CPC_SM_IDLE :
								(rx_sh[0] ? CPC_SM_RLO : CPC_SM_CMD);
							tx_sh <= rd_word[7:0]; // low byte first
						end
						CPC_SM_CMD: begin
							cmd_code <= rx_sh;
							smb_data_oe <= 1'b1;
							smb_st <= CPC_SM_WLO;
						end
						CPC_SM_WLO: begin
							lo_byte <= rx_sh;
							smb_data_oe <= 1'b1;
							smb_st <= CPC_SM_WHI;
						end
						CPC_SM_WHI: begin
							smb_data_oe <= 1'b1;
							smb_st <= CPC_SM_DONE;
						end
						CPC_SM_RLO: begin
							smb_data_oe <= 1'b0;
							tx_sh <= rd_word[15:8];
							smb_st <= CPC_SM_RHI;
						end
						CPC_SM_RHI, CPC_SM_DONE, CPC_SM_IDLE: begin
							// extra bytes are not acknowledged
							smb_data_oe <= 1'b0;
							smb_st <= CPC_SM_DONE;
						end
					endcase
				end else if (tx_state) begin
					smb_data_oe <= ~tx_sh[7];
					tx_sh <= {tx_sh[6:0], 1'b0};
				end
			end
		end
	end

	// register file: only implemented field bits are stored
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			opt_reg <= `CPC_RST_OPTIONS;
			cur_reg <= `CPC_RST_CHG_CURRENT;
			volt_reg <= `CPC_RST_CHG_VOLTAGE;
			inlim_reg <= `CPC_RST_INPUT_LIMIT;
		end else if (wr_strobe) begin
			unique case (cmd_code)
				`CPC_CMD_OPTIONS: opt_reg <= wr_word & ~`CPC_MASK_OPT_RO;
				`CPC_CMD_CHG_CURRENT: cur_reg <= wr_word & `CPC_MASK_CHG_CURRENT;
				`CPC_CMD_CHG_VOLTAGE: volt_reg <= wr_word & `CPC_MASK_CHG_VOLTAGE;
				`CPC_CMD_INPUT_LIMIT: inlim_reg <= wr_word & `CPC_MASK_INPUT_LIMIT;
				default: begin
					// identity codes and unmapped codes ignore writes
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fault supervision
	logic input_overcurrent_trip_latch; // input overcurrent latch-off
	logic [`CPC_TIMER_W-1:0] input_overcurrent_trip_cnt; // overcurrent persistence
	logic ovp_disable; // overvoltage lasted too long
	logic [`CPC_TIMER_W-1:0] ovp_cnt; // overvoltage persistence
	logic peak_block; // high side held off for this cycle
	logic thermal_off; // junction too hot
	cpc_batlow_state_t bl_st; // battery short sequence
	logic [`CPC_TIMER_W-1:0] bl_cnt; // battery short timer
	logic short_latch; // switch or inductor short latch-off
	logic [2:0] short_cnt [2]; // events: 1 high side, 0 low side
	logic [2:0] blank_cnt [2]; // cycles since gate turn-on
	logic chg_en_q; // previous charge enable, for soft-start
	cpc_drive_t drive_nx; // next drive levels
	wire hard_clear = ain.undervoltage_lockout | ain.adapter_detect_low;
	wire ov_act = ain.battery_overvoltage & (volt_reg != 16'h0000);
	wire input_overcurrent_trip_arm = ain.sys_overcurrent & opt_reg[`CPC_OPT_OVERCUR_EN];
	wire hs_detect_en = opt_reg[`CPC_OPT_HS_DETECT];
	wire [1:0] gate_on = {drive_out.high_side_switch_en, drive_out.low_side_switch_en};
	wire [1:0] short_cmp = {ain.high_side_short & hs_detect_en, ain.low_side_short};
	wire settings_ok = (cur_reg != 16'h0000) && (volt_reg != 16'h0000) &&
		(inlim_reg != 16'h0000);

	// input overcurrent: blank-out timer then latch
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			input_overcurrent_trip_cnt <= '0;
			input_overcurrent_trip_latch <= 1'b0;
		end else begin
			input_overcurrent_trip_cnt <= input_overcurrent_trip_arm ? input_overcurrent_trip_cnt + 1'b1 : '0;
			if (input_overcurrent_trip_arm && input_overcurrent_trip_cnt == INPUT_OVERCURRENT_TRIP_BLANK_CYC - 21'h1) begin
				input_overcurrent_trip_latch <= 1'b1;
			end else if (ain.adapter_detect_low) begin
				input_overcurrent_trip_latch <= 1'b0;
			end
		end
	end

	// overvoltage persistence, peak cutoff and thermal hysteresis
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ovp_cnt <= '0;
			ovp_disable <= 1'b0;
			peak_block <= 1'b0;
			thermal_off <= 1'b0;
		end else begin
			ovp_cnt <= ov_act ? ovp_cnt + 1'b1 : '0;
			if (ov_act && ovp_cnt == OVP_DISABLE_CYC - 21'h1) begin
				ovp_disable <= 1'b1;
			end else if (hard_clear) begin
				ovp_disable <= 1'b0;
			end
			if (ain.charge_peak_overcurrent) begin
				peak_block <= 1'b1;
			end else if (ain.cycle_start) begin
				peak_block <= 1'b0;
			end
			if (ain.temp_above_upper) begin
				thermal_off <= 1'b1;
			end else if (ain.temp_below_lower) begin
				thermal_off <= 1'b0;
			end
		end
	end

	// battery short: limit, reset after the first delay, restart after the second
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bl_st <= CPC_BL_IDLE;
			bl_cnt <= '0;
		end else begin
			unique case (bl_st)
				CPC_BL_IDLE: begin
					bl_cnt <= '0;
					if (ain.battery_short_low) begin
						bl_st <= CPC_BL_LIMIT;
					end
				end
				CPC_BL_LIMIT: begin
					bl_cnt <= bl_cnt + 1'b1;
					if (!ain.battery_short_low) begin
						bl_st <= CPC_BL_IDLE;
					end else if (bl_cnt == BATLOW_RESET_CYC - 21'h1) begin
						bl_st <= CPC_BL_RESET;
						bl_cnt <= '0;
					end
				end
				CPC_BL_RESET: begin
					bl_cnt <= bl_cnt + 1'b1;
					if (bl_cnt == BATLOW_RESTART_CYC - 21'h1) begin
						bl_st <= CPC_BL_IDLE;
					end
				end
				default: begin
					bl_st <= CPC_BL_IDLE;
				end
			endcase
		end
	end

	// short events: sample the comparator once blanking has run out
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			short_latch <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				short_cnt[i] <= 3'h0;
				blank_cnt[i] <= 3'h0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				// a pulse cut short before blanking ends is never sampled
				blank_cnt[i] <= !gate_on[i] ? 3'h0 :
					(blank_cnt[i] == 3'(`CPC_SHORT_BLANK_CYC)) ? blank_cnt[i] :
					blank_cnt[i] + 3'h1;
				if (hard_clear) begin
					short_cnt[i] <= 3'h0;
				end else if (gate_on[i] && short_cmp[i] &&
					blank_cnt[i] == 3'(`CPC_SHORT_BLANK_CYC - 1) &&
					short_cnt[i] != `CPC_SHORT_LIMIT) begin
					short_cnt[i] <= short_cnt[i] + 3'h1;
				end
			end
			if (short_cnt[0] == `CPC_SHORT_LIMIT || short_cnt[1] == `CPC_SHORT_LIMIT) begin
				short_latch <= 1'b1;
			end else if (hard_clear) begin
				short_latch <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// drive levels
	wire adapter_ok = ~hard_clear;
	wire chg_en = ~opt_reg[`CPC_OPT_INHIBIT] & settings_ok & adapter_ok & ~ov_act &
		~ovp_disable & ~thermal_off & ~input_overcurrent_trip_latch & ~short_latch &
		(bl_st != CPC_BL_RESET);
	wire bl_active = (bl_st != CPC_BL_IDLE) | ain.battery_short_low;
	always_comb begin
		drive_nx = '0;
		drive_nx.adapter_switch_en = adapter_ok & ~input_overcurrent_trip_latch & ~short_latch;
		drive_nx.reverse_block_switch_en = adapter_ok & ~input_overcurrent_trip_latch & ~short_latch;
		drive_nx.battery_switch_en = short_latch | ~adapter_ok;
		drive_nx.charge_enable = chg_en;
		drive_nx.high_side_switch_en = chg_en & ain.high_side_req & ~peak_block;
		drive_nx.low_side_switch_en = chg_en & (bl_active ? ain.bootstrap_refresh_req :
			ain.low_side_req);
		drive_nx.discharge_sink_en = ov_act;
		drive_nx.current_limit_en = bl_active;
		drive_nx.short_current_cap_en = bl_active;
		drive_nx.soft_start_req = chg_en & ~chg_en_q;
		drive_nx.regulator_low_limit = thermal_off;
		drive_nx.freq_adjust_en = opt_reg[`CPC_OPT_FREQ_EN];
		drive_nx.freq_raise = opt_reg[`CPC_OPT_FREQ_EN] & opt_reg[`CPC_OPT_FREQ_UP];
		drive_nx.ls_short_thresh_high = opt_reg[`CPC_OPT_LS_THRESH];
		drive_nx.hs_short_detect_en = hs_detect_en;
		drive_nx.peak_oc_level = (cur_reg >= `CPC_PEAK_STEP_HIGH) ? 2'h2 :
			(cur_reg >= `CPC_PEAK_STEP_MID) ? 2'h1 : 2'h0;
	end

	// register the drive levels
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			drive_out <= '0;
			chg_en_q <= 1'b0;
		end else begin
			drive_out <= drive_nx;
			chg_en_q <= chg_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	input_overcurrent_trip_latch_hold_a: assert property (input_overcurrent_trip_latch && !ain.adapter_detect_low |=> input_overcurrent_trip_latch)
		else $error("overcurrent latch dropped without adapter detect low");
	input_overcurrent_trip_switch_off_a: assert property (input_overcurrent_trip_latch |=> !drive_out.adapter_switch_en &&
		!drive_out.reverse_block_switch_en)
		else $error("adapter switches on during overcurrent latch");
	peak_block_hs_a: assert property (peak_block |=> !drive_out.high_side_switch_en)
		else $error("high side on after peak overcurrent");
	ovp_block_a: assert property (ov_act |=> !drive_out.high_side_switch_en &&
		!drive_out.low_side_switch_en && drive_out.discharge_sink_en)
		else $error("switching or sink wrong during overvoltage");
	sink_only_ovp_a: assert property (!ov_act |=> !drive_out.discharge_sink_en)
		else $error("discharge sink on without overvoltage");
	zero_volt_ovp_a: assert property (volt_reg == 16'h0000 |=> !drive_out.discharge_sink_en)
		else $error("overvoltage flagged with zero voltage setting");
	thermal_off_a: assert property (thermal_off |=> !drive_out.charge_enable &&
		drive_out.regulator_low_limit)
		else $error("charging during thermal shutdown");
	short_latch_a: assert property ($rose(short_latch) |-> $past(short_cnt[0]) == 3'h7 ||
		$past(short_cnt[1]) == 3'h7)
		else $error("short latch set before seventh event");
	short_drive_a: assert property (short_latch |=> drive_out.battery_switch_en &&
		!drive_out.adapter_switch_en)
		else $error("switches wrong during short latch");
	batlow_reset_a: assert property (bl_st == CPC_BL_RESET |=> !drive_out.charge_enable)
		else $error("charging during battery short reset");
	zero_set_a: assert property (!settings_ok |=> !drive_out.charge_enable)
		else $error("charging with a zero setting");
endmodule : cpc_charger_protection

//--- common/cpc_consts.svh
// register map, field layout, reset values and timing figures of the protection block
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH
// command codes of the word registers
`define CPC_CMD_OPTIONS 8'h12
`define CPC_CMD_CHG_CURRENT 8'h14
`define CPC_CMD_CHG_VOLTAGE 8'h15
`define CPC_CMD_INPUT_LIMIT 8'h3F
`define CPC_CMD_MAKER 8'hFE
`define CPC_CMD_PART 8'hFF
// reset values
`define CPC_RST_OPTIONS 16'hF902
`define CPC_RST_CHG_CURRENT 16'h0000
`define CPC_RST_CHG_VOLTAGE 16'h0000
`define CPC_RST_INPUT_LIMIT 16'h1000
// implemented field masks (7, 11 and 6 bits) and the read-only options bit
`define CPC_MASK_CHG_CURRENT 16'h1FC0
`define CPC_MASK_CHG_VOLTAGE 16'h7FF0
`define CPC_MASK_INPUT_LIMIT 16'h1F80
`define CPC_MASK_OPT_RO 16'h0010
// options bit positions
`define CPC_OPT_INHIBIT 0
`define CPC_OPT_OVERCUR_EN 1
`define CPC_OPT_ADAPTER_IND 4
`define CPC_OPT_LS_THRESH 7
`define CPC_OPT_HS_DETECT 8
`define CPC_OPT_FREQ_EN 9
`define CPC_OPT_FREQ_UP 10
// peak threshold level steps over the charge current register value
`define CPC_PEAK_STEP_MID 16'h0800
`define CPC_PEAK_STEP_HIGH 16'h1000
// number of short events that latch the charger off
`define CPC_SHORT_LIMIT 3'h7
// timing
`define CPC_CLK_PERIOD_NS 20
`define CPC_INPUT_OVERCURRENT_TRIP_BLANK_MS 4.2
`define CPC_OVP_DISABLE_MS 30
`define CPC_BATLOW_RESET_MS 1
`define CPC_BATLOW_RESTART_MS 4
`define CPC_SHORT_BLANK_NS 100
`define CPC_SHORT_BLANK_CYC ((`CPC_SHORT_BLANK_NS + `CPC_CLK_PERIOD_NS - 1) / `CPC_CLK_PERIOD_NS)
`define CPC_TIMER_W 21
`endif

//--- common/cpc_pkg.sv
// types shared by the charger protection block
package cpc_pkg;
	// comparator and modulator levels from the power stage
	typedef struct packed {
		logic sys_overcurrent;
		logic adapter_detect_low;
		logic undervoltage_lockout;
		logic charge_peak_overcurrent;
		logic battery_overvoltage;
		logic battery_short_low;
		logic temp_above_upper;
		logic temp_below_lower;
		logic high_side_short;
		logic low_side_short;
		logic high_side_req;
		logic low_side_req;
		logic cycle_start;
		logic bootstrap_refresh_req;
	} cpc_analog_in_t;
	// drive and select levels to the power stage
	typedef struct packed {
		logic adapter_switch_en;
		logic reverse_block_switch_en;
		logic battery_switch_en;
		logic high_side_switch_en;
		logic low_side_switch_en;
		logic discharge_sink_en;
		logic current_limit_en;
		logic short_current_cap_en;
		logic charge_enable;
		logic soft_start_req;
		logic regulator_low_limit;
		logic freq_adjust_en;
		logic freq_raise;
		logic ls_short_thresh_high;
		logic hs_short_detect_en;
		logic [1:0] peak_oc_level;
	} cpc_drive_t;
	// bus transfer phases
	typedef enum logic [2:0] {
		CPC_SM_IDLE = 3'h0,
		CPC_SM_ADDR = 3'h1,
		CPC_SM_CMD = 3'h3,
		CPC_SM_WLO = 3'h2,
		CPC_SM_WHI = 3'h6,
		CPC_SM_RLO = 3'h7,
		CPC_SM_RHI = 3'h5,
		CPC_SM_DONE = 3'h4
	} cpc_smb_state_t;
	// battery short sequence
	typedef enum logic [1:0] {
		CPC_BL_IDLE = 2'h0,
		CPC_BL_LIMIT = 2'h1,
		CPC_BL_RESET = 2'h3
	} cpc_batlow_state_t;
endpackage : cpc_pkg

//--- bench/cpc_host_model.sv
// host controller model: word transfers on the open-drain register bus
`timescale 1ns/100ps
module cpc_host_model #(
	parameter logic [6:0] ADDR = 7'h09 // bus address of the block
) (
	input wire logic ref_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low,
	output logic ack_err
);
	////////////////////////////////////////////////////////////////
	// bus idles with both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		ack_err = 1'b0;
	end
	// wait n reference cycles, then step off the edge
	task automatic hp(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : hp
	// start (s=1) or stop (s=0): data moves while clock high
	task automatic cnd(input logic s);
		hp(5);
		sda_low = !s;
		hp(15);
		scl = 1'b1;
		hp(20);
		sda_low = s;
		hp(20);
		scl = !s;
	endtask : cnd
	// one bit, data changed only while clock low; level seen comes back
	task automatic bt(input logic b, output logic s);
		hp(5);
		sda_low = !b;
		hp(15);
		scl = 1'b1;
		hp(20);
		s = sda;
		scl = 1'b0;
	endtask : bt
	// byte msb first, then the acknowledge bit
	task automatic by(input logic [7:0] v, input logic w, input logic nak, output logic [7:0] r);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bt(v[i], r[i]);
		end
		bt(w | nak, s);
		if (w && s !== 1'b0) begin
			ack_err = 1'b1; // block left a byte unacknowledged
		end
	endtask : by
	////////////////////////////////////////////////////////////////
	// word write: address, command, low byte, high byte
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		logic [7:0] r;
		cnd(1'b1);
		by({ADDR, 1'b0}, 1'b1, 1'b0, r);
		by(c, 1'b1, 1'b0, r);
		by(d[7:0], 1'b1, 1'b0, r);
		by(d[15:8], 1'b1, 1'b0, r);
		cnd(1'b0);
	endtask : wr
	// word read: repeated start, ack low byte, nack high byte
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		logic [7:0] r;
		cnd(1'b1);
		by({ADDR, 1'b0}, 1'b1, 1'b0, r);
		by(c, 1'b1, 1'b0, r);
		cnd(1'b1);
		by({ADDR, 1'b1}, 1'b1, 1'b0, r);
		by(8'hFF, 1'b0, 1'b0, d[7:0]);
		by(8'hFF, 1'b0, 1'b1, d[15:8]);
		cnd(1'b0);
	endtask : rd
endmodule : cpc_host_model

//--- bench/tb_top.sv
// self-checking bench of the charger protection block
`timescale 1ns/100ps
`include "cpc_consts.svh"
module tb_top import cpc_pkg::*;;
	localparam logic [15:0] MK = 16'h0C3A; // arbitrary value
	localparam logic [15:0] PT = 16'h07E1; // arbitrary value
	logic ref_clk = 1'b0; // 50 MHz
	logic srst = 1'b1; // held 4 cycles
	logic scl, sda_low, ack_err, sdo, oe;
	wire sda = !(sda_low | oe); // pull-up unless pulled
	cpc_analog_in_t ai; // power stage levels
	cpc_drive_t dr; // power stage drive
	logic [15:0] rv; // word read back
	int miscompares = 0;
	int n_compared = 0;
	logic [7:0] rc [7] = '{`CPC_CMD_OPTIONS, `CPC_CMD_CHG_CURRENT,
		`CPC_CMD_CHG_VOLTAGE, `CPC_CMD_INPUT_LIMIT, `CPC_CMD_MAKER, `CPC_CMD_PART, 8'h20};
	logic [15:0] re [7] = '{`CPC_RST_OPTIONS | 16'h0010, `CPC_RST_CHG_CURRENT,
		`CPC_RST_CHG_VOLTAGE, `CPC_RST_INPUT_LIMIT, MK, PT, 16'h0000};
	logic [15:0] wm [7] = '{16'h0, `CPC_MASK_CHG_CURRENT, `CPC_MASK_CHG_VOLTAGE,
		`CPC_MASK_INPUT_LIMIT, 16'h0, 16'h0, 16'h0};
	logic [15:0] pc [3] = '{16'h0400, 16'h0800, 16'h1000};
	initial forever #10 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////
	cpc_charger_protection #(.MAKER_CODE(MK), .PART_CODE(PT), .INPUT_OVERCURRENT_TRIP_BLANK_CYC(21'd20),
		.OVP_DISABLE_CYC(21'd30), .BATLOW_RESET_CYC(21'd10), .BATLOW_RESTART_CYC(21'd20))
		cpc_charger_protection_inst (.ref_clk(ref_clk), .srst(srst), .smb_clk_in(scl),
		.smb_data_in(sda), .smb_data_out(sdo), .smb_data_oe(oe), .analog_in(ai),
		.drive_out(dr));
	cpc_host_model cpc_host_model_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl),
		.sda_low(sda_low), .ack_err(ack_err));
	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : ck
	// let n cycles pass, land off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	// bus write, then time for the drive to follow
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		cpc_host_model_inst.wr(c, d);
		cyc(8);
	endtask : wr
	// bus read and compare
	task automatic rk(input logic [7:0] c, input logic [15:0] e);
		cpc_host_model_inst.rd(c, rv);
		ck("reg", e, rv);
	endtask : rk
	// report counts and verdict
	task automatic conclude;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	// hang guard
	initial begin
		repeat (95000) @(posedge ref_clk);
		miscompares++;
		conclude;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		ai = '0;
		ai.temp_below_lower = 1'b1;
		ai.battery_overvoltage = 1'b1;
		cyc(4);
		srst = 1'b0;
		cyc(8);
		ck("chg_en", 0, dr.charge_enable);
		// overvoltage level ignored while the voltage setting is zero
		ck("ovp", 0, dr.discharge_sink_en);
		ai.battery_overvoltage = 1'b0;
		for (int i = 0; i < 7; i++) begin
			rk(rc[i], re[i]);
		end
		for (int i = 1; i < 6; i++) begin
			wr(rc[i], 16'hFFFF);
			rk(rc[i], re[i] | wm[i]);
		end
		wr(`CPC_CMD_CHG_VOLTAGE, 16'h1000);
		wr(`CPC_CMD_INPUT_LIMIT, 16'h0400);
		for (int i = 0; i < 3; i++) begin
			wr(`CPC_CMD_CHG_CURRENT, pc[i]);
			ck("peak", i, dr.peak_oc_level);
		end
		ck("chg_en", 1, dr.charge_enable);
		// adjust on, raise, high low-side threshold, high-side detect off
		wr(`CPC_CMD_OPTIONS, 16'hFE82);
		ck("opt", 16'hE, {dr.freq_adjust_en, dr.freq_raise, dr.ls_short_thresh_high,
			dr.hs_short_detect_en});
		wr(`CPC_CMD_OPTIONS, 16'hFB02);
		ck("opt", 16'h9, {dr.freq_adjust_en, dr.freq_raise, dr.ls_short_thresh_high,
			dr.hs_short_detect_en});
		// peak cut holds high side off until the next cycle
		ai.high_side_req = 1'b1;
		ai.charge_peak_overcurrent = 1'b1;
		cyc(4);
		ai.charge_peak_overcurrent = 1'b0;
		cyc(8);
		ck("hs", 0, dr.high_side_switch_en);
		ai.cycle_start = 1'b1;
		cyc(4);
		ai.cycle_start = 1'b0;
		cyc(8);
		ck("hs", 1, dr.high_side_switch_en);
		// overvoltage: sink on, both gates off, then full disable
		ai.battery_overvoltage = 1'b1;
		cyc(8);
		ck("ovp", 16'h4, {dr.discharge_sink_en, dr.high_side_switch_en,
			dr.low_side_switch_en});
		cyc(40);
		ai.battery_overvoltage = 1'b0;
		cyc(8);
		ck("ovp", 16'h0, {dr.discharge_sink_en, dr.charge_enable});
		ai.adapter_detect_low = 1'b1;
		cyc(8);
		ai.adapter_detect_low = 1'b0;
		cyc(8);
		ck("chg_en", 1, dr.charge_enable);
		// thermal trip and hysteresis
		ai.temp_below_lower = 1'b0;
		ai.temp_above_upper = 1'b1;
		cyc(8);
		ai.temp_above_upper = 1'b0;
		cyc(8);
		ck("hot", 16'h1, {dr.charge_enable, dr.regulator_low_limit});
		ai.temp_below_lower = 1'b1;
		cyc(8);
		ck("hot", 16'h2, {dr.charge_enable, dr.regulator_low_limit});
		// input overcurrent: ignored with bit 1 clear, latched with it set
		wr(`CPC_CMD_OPTIONS, 16'hFB00);
		ai.sys_overcurrent = 1'b1;
		cyc(40);
		ck("acsw", 1, dr.adapter_switch_en);
		wr(`CPC_CMD_OPTIONS, 16'hFB02);
		cyc(40);
		ai.sys_overcurrent = 1'b0;
		wr(`CPC_CMD_CHG_CURRENT, 16'h0400);
		ck("acsw", 0, {dr.adapter_switch_en, dr.reverse_block_switch_en});
		ai.adapter_detect_low = 1'b1;
		cyc(8);
		ai.adapter_detect_low = 1'b0;
		cyc(8);
		ck("acsw", 16'h3, {dr.adapter_switch_en, dr.reverse_block_switch_en});
		// battery short: limit, reset after 10, restart after 20 more
		ai.high_side_req = 1'b0;
		ai.low_side_req = 1'b1;
		ai.battery_short_low = 1'b1;
		cyc(6);
		ck("bl", 16'h6, {dr.current_limit_en, dr.short_current_cap_en,
			dr.low_side_switch_en});
		cyc(14);
		ck("chg_en", 0, dr.charge_enable);
		cyc(20);
		ck("chg_en", 1, dr.charge_enable);
		// gate shorts: a pulse inside blanking is ignored, the seventh event latches
		ai.battery_short_low = 1'b0;
		ai.low_side_req = 1'b0;
		cyc(8);
		ai.low_side_short = 1'b1;
		ai.low_side_req = 1'b1;
		cyc(3);
		ai.low_side_req = 1'b0;
		cyc(10);
		for (int i = 0; i < 7; i++) begin
			if (i == 6) begin
				ck("acsw", 1, dr.adapter_switch_en);
			end
			ai.low_side_req = 1'b1;
			cyc(10);
			ai.low_side_req = 1'b0;
			cyc(10);
		end
		ck("short", 16'h1, {dr.adapter_switch_en, dr.battery_switch_en});
		// lockout clears the short latch
		ai.low_side_short = 1'b0;
		ai.undervoltage_lockout = 1'b1;
		cyc(8);
		ai.undervoltage_lockout = 1'b0;
		cyc(8);
		ck("short", 16'h2, {dr.adapter_switch_en, dr.battery_switch_en});
		ck("ack", 0, ack_err);
		conclude;
	end
endmodule : tb_top
